/* File: rtcaim_pkg.sv */
// Purpose: shared constants for the rtc alarm, interrupt and supply monitor
// Assumes: 10 MHz clock, registers reached by 4-bit index with 8-bit data
// Notes: timing counts are derived from times in their own unit
package rtcaim_pkg;
    // register indices
    localparam logic [3:0] REG_CTRL1_IDX = 4'he;
    localparam logic [3:0] REG_CTRL2_IDX = 4'hf;
    // control 1 fields
    localparam int C1_WEEKDAY_ALARM_ENABLE_BIT = 7;
    localparam int C1_DAILY_ALARM_ENABLE_BIT = 6;
    localparam int C1_MISC_HI = 5;
    localparam int C1_MISC_LO = 3;
    localparam int C1_PSEL_HI = 2;
    localparam int C1_PSEL_LO = 0;
    // control 2 fields
    localparam int C2_BATTERY_THRESHOLD_SELECT_BIT = 7;
    localparam int C2_BLOW_BIT = 6;
    localparam int C2_PERIODIC_FLAG_BIT = 2;
    localparam int C2_WEEKDAY_ALARM_FLAG_BIT = 1;
    localparam int C2_DAILY_ALARM_FLAG_BIT = 0;
    // reset values
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [2:0] MISC_RESET = 3'h0;
    // sub-second phase bits for pulse waveforms
    localparam int PHASE_2HZ_BIT = 0;
    localparam int PHASE_1HZ_BIT = 1;
    // periodic select encodings
    typedef enum logic [2:0] {
        PSEL_OFF = 3'b000,
        PSEL_FIXED_LOW = 3'b001,
        PSEL_PULSE_2HZ = 3'b010,
        PSEL_PULSE_1HZ = 3'b011,
        PSEL_LEVEL_SEC = 3'b100,
        PSEL_LEVEL_MIN = 3'b101,
        PSEL_LEVEL_HOUR = 3'b110,
        PSEL_LEVEL_MONTH = 3'b111
    } rtcaim_psel_t;
    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam real SAMPLE_WINDOW_MS = 7.8;
    localparam int SAMPLE_WINDOW_CYC = int'($floor(SAMPLE_WINDOW_MS * CLK_HZ / 1000.0));
    localparam real RESET_RELEASE_DELAY_MS = 100.0;
    localparam int RESET_RELEASE_DELAY_CYC = int'($ceil(RESET_RELEASE_DELAY_MS * CLK_HZ / 1000.0));
endpackage

/* File: rtcaim_batt_sampler.sv */
// Purpose: once-per-second battery supply sampler with short window
// Assumes: sec_tick is a one-cycle pulse at each second increment
// Notes: comparator enabled only inside the window to save current
`timescale 1ns/1ps
module rtcaim_batt_sampler #(
    parameter int WINDOW_CYC = rtcaim_pkg::SAMPLE_WINDOW_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sec_tick,
    input wire logic suspend,
    input wire logic threshold_select,
    input wire logic batt_above_high,
    input wire logic batt_above_low,
    output logic cmp_enable,
    output logic low_detect
);
    import rtcaim_pkg::*;
    localparam int CW = $clog2(WINDOW_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(WINDOW_CYC - 1);

    typedef struct packed {
        logic active;
        logic [CW-1:0] cnt;
        logic low;
    } rtcaim_bs_t;

    rtcaim_bs_t s_reg;
    rtcaim_bs_t s_next;
    logic below;

    // one threshold for both directions, picked by select bit
    assign below = threshold_select ? ~batt_above_low : ~batt_above_high;

    // window sequencing and end-of-window sample
    always_comb begin
        s_next = s_reg;
        s_next.low = 1'b0;
        if (s_reg.active) begin
            if (suspend) begin
                s_next.active = 1'b0;
            end else if (s_reg.cnt == LAST) begin
                s_next.active = 1'b0;
                s_next.low = below;
            end else begin
                s_next.cnt = s_reg.cnt + CW'(1);
            end
        end else if (sec_tick && !suspend) begin
            s_next.active = 1'b1;
            s_next.cnt = '0;
        end
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cmp_enable = s_reg.active;
    assign low_detect = s_reg.low;
endmodule // rtcaim_batt_sampler

/* File: rtcaim_monitor.sv */
// Purpose: alarm, periodic interrupt, flag registers and supply monitors
// Assumes: time counters and sub-second phase come from the counter chain
// Notes: interrupt and host reset pins are open drain, driven low only
`timescale 1ns/1ps
module rtcaim_monitor #(
    parameter int RESET_DELAY_CYC = rtcaim_pkg::RESET_RELEASE_DELAY_CYC,
    parameter int SAMPLE_CYC = rtcaim_pkg::SAMPLE_WINDOW_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // running time counters
    input wire logic [2:0] cur_weekday,
    input wire logic [5:0] cur_hour,
    input wire logic [6:0] cur_minute,
    // alarm settings
    input wire logic [6:0] alarm_w_weekdays,
    input wire logic [5:0] alarm_w_hour,
    input wire logic [6:0] alarm_w_minute,
    input wire logic [5:0] alarm_d_hour,
    input wire logic [6:0] alarm_d_minute,
    // counter chain events
    input wire logic sec_tick,
    input wire logic min_tick,
    input wire logic hour_tick,
    input wire logic month_tick,
    input wire logic [1:0] sub_second,
    // supply and oscillator status
    input wire logic main_supply_ok,
    input wire logic osc_running,
    input wire logic batt_above_high,
    input wire logic batt_above_low,
    output logic batt_cmp_enable,
    // interrupt pin, open drain
    input wire logic interrupt_out_n_in,
    output logic interrupt_out_n_out,
    output logic interrupt_out_n_oe,
    // host reset pin, open drain
    input wire logic host_reset_out_n_in,
    output logic host_reset_out_n_out,
    output logic host_reset_out_n_oe
);
    import rtcaim_pkg::*;

    localparam int RW = $clog2(RESET_DELAY_CYC + 1);
    localparam logic [RW-1:0] DELAY_LAST = RW'(RESET_DELAY_CYC - 1);

    // whole module state
    typedef struct packed {
        logic weekday_alarm_enable;
        logic daily_alarm_enable;
        logic [2:0] misc;
        logic [2:0] psel;
        logic battery_threshold_select;
        logic batt_low;
        logic periodic_flag;
        logic weekday_alarm_flag;
        logic daily_alarm_flag;
        logic match_w_prev;
        logic match_d_prev;
        logic [RW-1:0] rst_cnt;
        logic host_low;
        logic int_low;
        logic cmp_en;
        logic [7:0] rdata;
    } rtcaim_state_t;

    rtcaim_state_t s_reg;
    rtcaim_state_t s_next;

    logic match_w;
    logic match_d;
    logic match_w_rise;
    logic match_d_rise;
    logic periodic_event;
    logic pulse_low;
    logic periodic_low;
    logic level_mode;
    logic wr_c1;
    logic wr_c2;
    logic batt_low_detect;
    logic batt_cmp_en_raw;
    logic [7:0] c1_view;
    logic [7:0] c2_view;

    // register index decode, used for reads and writes
    function automatic logic idx_hit(input logic [3:0] a, input logic [3:0] idx);
        idx_hit = (a == idx);
    endfunction

    // weekday bit of a one-hot weekday mask
    function automatic logic day_selected(input logic [6:0] mask, input logic [2:0] day);
        day_selected = mask[day];
    endfunction

    assign wr_c1 = reg_wr && idx_hit(reg_addr, REG_CTRL1_IDX);
    assign wr_c2 = reg_wr && idx_hit(reg_addr, REG_CTRL2_IDX);

    // alarm comparators against running counters
    assign match_w = day_selected(alarm_w_weekdays, cur_weekday)
                     && (alarm_w_hour == cur_hour)
                     && (alarm_w_minute == cur_minute);
    assign match_d = (alarm_d_hour == cur_hour)
                     && (alarm_d_minute == cur_minute);

    // only a fresh match counts, not one already standing at enable
    assign match_w_rise = match_w && !s_reg.match_w_prev && s_reg.weekday_alarm_enable;
    assign match_d_rise = match_d && !s_reg.match_d_prev && s_reg.daily_alarm_enable;

    // periodic event and level mode select
    always_comb begin
        level_mode = 1'b1;
        case (rtcaim_psel_t'(s_reg.psel))
            PSEL_LEVEL_SEC: periodic_event = sec_tick;
            PSEL_LEVEL_MIN: periodic_event = min_tick;
            PSEL_LEVEL_HOUR: periodic_event = hour_tick;
            PSEL_LEVEL_MONTH: periodic_event = month_tick;
            default: begin
                periodic_event = 1'b0;
                level_mode = 1'b0;
            end
        endcase
    end

    // pulse waveforms, low in first half of each period
    always_comb begin
        case (rtcaim_psel_t'(s_reg.psel))
            PSEL_PULSE_2HZ: pulse_low = !sub_second[PHASE_2HZ_BIT];
            PSEL_PULSE_1HZ: pulse_low = !sub_second[PHASE_1HZ_BIT];
            default: pulse_low = 1'b0;
        endcase
    end

    // periodic contribution to the interrupt pin
    always_comb begin
        case (rtcaim_psel_t'(s_reg.psel))
            PSEL_OFF: periodic_low = 1'b0;
            PSEL_FIXED_LOW: periodic_low = 1'b1;
            PSEL_PULSE_2HZ: periodic_low = pulse_low;
            PSEL_PULSE_1HZ: periodic_low = pulse_low;
            default: periodic_low = 1'b0; // level modes use the next flag below
        endcase
    end

    // register read views
    always_comb begin
        c1_view = DATA_ZERO;
        c1_view[C1_WEEKDAY_ALARM_ENABLE_BIT] = s_reg.weekday_alarm_enable;
        c1_view[C1_DAILY_ALARM_ENABLE_BIT] = s_reg.daily_alarm_enable;
        c1_view[C1_MISC_HI:C1_MISC_LO] = s_reg.misc;
        c1_view[C1_PSEL_HI:C1_PSEL_LO] = s_reg.psel;
    end

    always_comb begin
        c2_view = DATA_ZERO;
        c2_view[C2_BATTERY_THRESHOLD_SELECT_BIT] = s_reg.battery_threshold_select;
        c2_view[C2_BLOW_BIT] = s_reg.batt_low;
        c2_view[C2_PERIODIC_FLAG_BIT] = s_reg.periodic_flag || pulse_low;
        c2_view[C2_WEEKDAY_ALARM_FLAG_BIT] = s_reg.weekday_alarm_flag;
        c2_view[C2_DAILY_ALARM_FLAG_BIT] = s_reg.daily_alarm_flag;
    end

    // battery window sampler
    rtcaim_batt_sampler #(
        .WINDOW_CYC(SAMPLE_CYC)
    ) u_batt (
        .clk(clk),
        .nrst(nrst),
        .sec_tick(sec_tick),
        .suspend(s_reg.batt_low),
        .threshold_select(s_reg.battery_threshold_select),
        .batt_above_high(batt_above_high),
        .batt_above_low(batt_above_low),
        .cmp_enable(batt_cmp_en_raw),
        .low_detect(batt_low_detect)
    );

    // next state of the whole block
    always_comb begin
        s_next = s_reg;
        s_next.match_w_prev = match_w;
        s_next.match_d_prev = match_d;
        s_next.cmp_en = batt_cmp_en_raw;

        // control 1 writes; enables stay as written
        if (wr_c1) begin
            s_next.weekday_alarm_enable = reg_wdata[C1_WEEKDAY_ALARM_ENABLE_BIT];
            s_next.daily_alarm_enable = reg_wdata[C1_DAILY_ALARM_ENABLE_BIT];
            s_next.misc = reg_wdata[C1_MISC_HI:C1_MISC_LO];
            s_next.psel = reg_wdata[C1_PSEL_HI:C1_PSEL_LO];
        end

        // control 2 writes: flags accept only a clearing 0
        if (wr_c2) begin
            s_next.battery_threshold_select = reg_wdata[C2_BATTERY_THRESHOLD_SELECT_BIT];
            if (!reg_wdata[C2_BLOW_BIT]) begin
                s_next.batt_low = 1'b0;
            end
            if (!reg_wdata[C2_PERIODIC_FLAG_BIT]) begin
                s_next.periodic_flag = 1'b0;
            end
            if (!reg_wdata[C2_WEEKDAY_ALARM_FLAG_BIT]) begin
                s_next.weekday_alarm_flag = 1'b0;
            end
            if (!reg_wdata[C2_DAILY_ALARM_FLAG_BIT]) begin
                s_next.daily_alarm_flag = 1'b0;
            end
        end

        // hardware sets win over a clear in the same cycle
        if (batt_low_detect) begin
            s_next.batt_low = 1'b1;
        end
        if (periodic_event) begin
            s_next.periodic_flag = 1'b1;
        end
        if (match_w_rise) begin
            s_next.weekday_alarm_flag = 1'b1;
        end
        if (match_d_rise) begin
            s_next.daily_alarm_flag = 1'b1;
        end

        // interrupt pin is an or of all active-low sources; level flag drives pin in the same cycle it sets
        s_next.int_low = (s_next.weekday_alarm_flag && s_next.weekday_alarm_enable)
                         || (s_next.daily_alarm_flag && s_next.daily_alarm_enable)
                         || (level_mode && s_next.periodic_flag)
                         || periodic_low;

        // main supply monitor, looked at every cycle
        if (!main_supply_ok) begin
            s_next.host_low = 1'b1;
            s_next.rst_cnt = '0;
        end else if (s_reg.host_low) begin
            if (!osc_running) begin
                s_next.rst_cnt = '0;
            end else if (s_reg.rst_cnt == DELAY_LAST) begin
                s_next.host_low = 1'b0;
            end else begin
                s_next.rst_cnt = s_reg.rst_cnt + RW'(1);
            end
        end

        // registered read data, held between reads
        if (reg_rd) begin
            if (idx_hit(reg_addr, REG_CTRL1_IDX)) begin
                s_next.rdata = c1_view;
            end else if (idx_hit(reg_addr, REG_CTRL2_IDX)) begin
                s_next.rdata = c2_view;
            end else begin
                s_next.rdata = DATA_ZERO;
            end
        end
    end

    // state register; host reset held low from reset until delay expires
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
            s_reg.host_low <= 1'b1;
            s_reg.misc <= MISC_RESET;
            s_reg.rdata <= DATA_ZERO;
        end else begin
            s_reg <= s_next;
        end
    end

    // pin drive: value always low, enable pulls the line
    assign interrupt_out_n_out = 1'b0;
    assign interrupt_out_n_oe = s_reg.int_low;
    assign host_reset_out_n_out = 1'b0;
    assign host_reset_out_n_oe = s_reg.host_low;
    assign batt_cmp_enable = s_reg.cmp_en;
    assign reg_rdata = s_reg.rdata;
endmodule // rtcaim_monitor

/* File: rtcaim_monitor_chk.sv */
// Purpose: port-level checker for the alarm, interrupt and supply monitor
// Assumes: one clock domain, control 1 image rebuilt from register writes
// Notes: attached by bind from the testbench top file
`timescale 1ns/1ps
module rtcaim_monitor_chk #(
    parameter int RESET_DELAY_CYC = 20,
    parameter int SAMPLE_CYC = 10
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [5:0] cur_hour,
    input wire logic [6:0] cur_minute,
    input wire logic [5:0] alarm_d_hour,
    input wire logic [6:0] alarm_d_minute,
    input wire logic sec_tick,
    input wire logic main_supply_ok,
    input wire logic osc_running,
    input wire logic batt_cmp_enable,
    input wire logic interrupt_out_n_oe,
    input wire logic host_reset_out_n_oe
);
    localparam int SW = SAMPLE_CYC - 7;
    logic [7:0] c1_reg;
    logic [31:0] ok_reg;
    logic dm;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // control 1 image and supply-good run length
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            c1_reg <= 8'h00;
            ok_reg <= 32'h0;
        end else begin
            if (reg_wr && reg_addr == 4'he) c1_reg <= reg_wdata;
            ok_reg <= (main_supply_ok && osc_running) ? ok_reg + 32'h1 : 32'h0;
        end
    end
    assign dm = (cur_hour == alarm_d_hour) && (cur_minute == alarm_d_minute);
    AST_HRST_FALL: assert property (!main_supply_ok |=> host_reset_out_n_oe)
        else $error("host reset not asserted");
    AST_HRST_HOLD: assert property (ok_reg < RESET_DELAY_CYC |-> host_reset_out_n_oe)
        else $error("host reset released early");
    AST_HRST_REL: assert property (ok_reg >= RESET_DELAY_CYC + 3 |-> !host_reset_out_n_oe)
        else $error("host reset released late");
    AST_WIN_CAUSE: assert property ($rose(batt_cmp_enable) |-> $past(sec_tick, 2))
        else $error("window without second tick");
    AST_WIN_LEN: assert property ($rose(batt_cmp_enable) |-> batt_cmp_enable[*8] ##SW !batt_cmp_enable)
        else $error("window length wrong");
    AST_DAY_FIRE: assert property (c1_reg[6] && dm && !$past(dm) |=> interrupt_out_n_oe)
        else $error("daily alarm did not fire");
    AST_LEVEL: assert property (c1_reg[2:0] == 3'h4 && sec_tick |=> interrupt_out_n_oe)
        else $error("level interrupt missing");
    AST_FIXED: assert property (c1_reg[2:0] == 3'h1 && $past(c1_reg[2:0]) == 3'h1 |-> interrupt_out_n_oe)
        else $error("fixed low not driven");
    AST_RD_C1: assert property (reg_rd && reg_addr == 4'he |=> reg_rdata == $past(c1_reg))
        else $error("control 1 read wrong");
    AST_POR: assert property ($rose(nrst) |-> !interrupt_out_n_oe)
        else $error("interrupt active after reset");
endmodule // rtcaim_monitor_chk

/* File: rtcaim_host_side.sv */
// Purpose: far side model, pull-ups on open-drain pins and counter chain events
// Assumes: one second shortened to 40 clocks
// Notes: pins read high whenever nobody pulls them low
`timescale 1ns/1ps
module rtcaim_host_side (
    input wire logic clk,
    input wire logic nrst,
    input wire logic interrupt_out_n_oe,
    input wire logic host_reset_out_n_oe,
    output logic interrupt_out_n_in,
    output logic host_reset_out_n_in,
    output logic sec_tick,
    output logic min_tick,
    output logic hour_tick,
    output logic month_tick,
    output logic [1:0] sub_second
);
    logic [5:0] cnt;
    logic [2:0] secs;
    // pull-up resolution of both pins
    assign interrupt_out_n_in = interrupt_out_n_oe ? 1'b0 : 1'b1;
    assign host_reset_out_n_in = host_reset_out_n_oe ? 1'b0 : 1'b1;
    // shortened counter chain
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 6'h0;
            secs <= 3'h0;
        end else if (cnt == 6'd39) begin
            cnt <= 6'h0;
            secs <= secs + 3'h1;
        end else begin
            cnt <= cnt + 6'h1;
        end
    end
    assign sec_tick = (cnt == 6'd39);
    assign min_tick = sec_tick && secs[0];
    assign hour_tick = sec_tick && (secs[1:0] == 2'h3);
    assign month_tick = sec_tick && (secs == 3'h7);
    assign sub_second = cnt < 6'd10 ? 2'h0 : cnt < 6'd20 ? 2'h1 : cnt < 6'd30 ? 2'h2 : 2'h3;
endmodule // rtcaim_host_side

/* File: rtc_alarm_interrupt_monitor_test.sv */
// Purpose: self-checking bench for the alarm, interrupt and supply monitor
// Assumes: shortened reset delay and sampling window
// Notes: m1 and m2 hold the expected control register images
`timescale 1ns/1ps
module rtc_alarm_interrupt_monitor_test;
    import rtcaim_pkg::*;
    localparam int RDC = 20;
    logic clk = 1'b0;
    logic nrst, reg_wr, reg_rd, sec_tick, min_tick, hour_tick, month_tick, seen_en;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [2:0] cur_weekday;
    logic [5:0] cur_hour, alarm_w_hour, alarm_d_hour;
    logic [6:0] cur_minute, alarm_w_weekdays, alarm_w_minute, alarm_d_minute;
    logic [1:0] sub_second;
    logic main_supply_ok, osc_running, batt_above_high, batt_above_low, batt_cmp_enable;
    logic interrupt_out_n_in, interrupt_out_n_out, interrupt_out_n_oe;
    logic host_reset_out_n_in, host_reset_out_n_out, host_reset_out_n_oe;
    logic [31:0] seed = 32'h8f060277;
    logic [31:0] r;
    int n_errors = 0;
    int cmp_count = 0;
    int m1, m2;
    // clock
    always #50 clk = ~clk;
    rtcaim_monitor #(.RESET_DELAY_CYC(RDC), .SAMPLE_CYC(10)) u_rtcaim_monitor (.clk, .nrst, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .reg_rdata, .cur_weekday, .cur_hour, .cur_minute, .alarm_w_weekdays, .alarm_w_hour,
        .alarm_w_minute, .alarm_d_hour, .alarm_d_minute, .sec_tick, .min_tick, .hour_tick, .month_tick, .sub_second,
        .main_supply_ok, .osc_running, .batt_above_high, .batt_above_low, .batt_cmp_enable, .interrupt_out_n_in,
        .interrupt_out_n_out, .interrupt_out_n_oe, .host_reset_out_n_in, .host_reset_out_n_out, .host_reset_out_n_oe);
    rtcaim_host_side u_rtcaim_host_side (.clk, .nrst, .interrupt_out_n_oe, .host_reset_out_n_oe, .interrupt_out_n_in,
        .host_reset_out_n_in, .sec_tick, .min_tick, .hour_tick, .month_tick, .sub_second);
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rc(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, e);
    endtask
    task pins(input logic [1:0] e);
        @(negedge clk);
        chk({4'h0, interrupt_out_n_out, host_reset_out_n_out, interrupt_out_n_in, host_reset_out_n_in}, {6'h00, e});
    endtask
    task print_verdict();
        $display("counts: errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // main sequence
    initial begin
        {reg_wr, reg_rd, nrst, reg_addr, reg_wdata, cur_hour, cur_minute, alarm_w_hour, alarm_w_minute} = '0;
        {alarm_d_hour, alarm_d_minute} = '0;
        {main_supply_ok, osc_running, batt_above_high, batt_above_low} = 4'hf;
        cur_weekday = 3'h2;
        alarm_w_weekdays = 7'h08;
        m1 = 0;
        m2 = 0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (RDC + 5) @(posedge clk);
        pins(2'b11);
        rc(4'he, 8'h00);
        rc(4'hf, 8'h00);
        rc(4'h3, 8'h00);
        r = xs();
        m1 = {2'b00, r[5:3], 3'b000};
        wr(4'he, m1[7:0]);
        rc(4'he, m1[7:0]);
        $display("test registers done");
        @(posedge clk);
        main_supply_ok <= 1'b0;
        osc_running <= 1'b0;
        pins(2'b11);
        pins(2'b10);
        @(posedge clk);
        main_supply_ok <= 1'b1;
        repeat (RDC + 5) @(posedge clk);
        pins(2'b10);
        @(posedge clk);
        osc_running <= 1'b1;
        repeat (RDC - 2) @(posedge clk);
        pins(2'b10);
        repeat (5) @(posedge clk);
        pins(2'b11);
        $display("test host reset done");
        r = xs();
        @(posedge clk);
        {alarm_d_minute, alarm_w_minute, cur_minute} <= {r[6:0], r[6:0], ~r[6:0]};
        {alarm_d_hour, alarm_w_hour, cur_hour} <= {r[13:8], r[13:8], r[13:8]};
        m1 = 8'h40;
        wr(4'he, 8'h40);
        @(posedge clk);
        cur_minute <= r[6:0];
        repeat (3) @(posedge clk);
        pins(2'b01);
        m2 = 8'h01;
        rc(4'hf, m2[7:0]);
        wr(4'hf, 8'h07);
        rc(4'hf, m2[7:0]);
        m2 = 0;
        wr(4'hf, 8'h00);
        pins(2'b11);
        rc(4'he, 8'h40);
        wr(4'he, 8'h00);
        wr(4'he, 8'h40);
        repeat (3) @(posedge clk);
        pins(2'b11);
        rc(4'hf, 8'h00);
        @(posedge clk);
        cur_minute <= ~r[6:0];
        repeat (3) @(posedge clk);
        cur_minute <= r[6:0];
        repeat (3) @(posedge clk);
        rc(4'hf, 8'h01);
        wr(4'hf, 8'h00);
        m1 = 8'h80;
        wr(4'he, 8'h80);
        @(posedge clk);
        cur_weekday <= 3'h3;
        repeat (3) @(posedge clk);
        pins(2'b01);
        rc(4'hf, 8'h02);
        wr(4'he, 8'h00);
        wr(4'hf, 8'h00);
        $display("test alarms done");
        for (int p = 1; p < 8; p++) begin
            wr(4'he, p[7:0]);
            for (int i = 0; i < 400 && interrupt_out_n_in !== 1'b0; i++) @(negedge clk);
            chk({6'h00, interrupt_out_n_in, host_reset_out_n_in}, 8'h01);
            if (p >= 4) rc(4'hf, 8'h04);
            wr(4'he, 8'h00);
            wr(4'hf, 8'h00);
            repeat (3) @(posedge clk);
            pins(2'b11);
        end
        $display("test periodic done");
        @(posedge clk);
        batt_above_high <= 1'b0;
        repeat (90) @(posedge clk);
        m2 = 8'h40;
        rc(4'hf, m2[7:0]);
        seen_en = 1'b0;
        repeat (45) @(negedge clk) seen_en |= batt_cmp_enable;
        chk({7'h00, seen_en}, 8'h00);
        m2 = 8'h80;
        wr(4'hf, 8'h80);
        repeat (90) @(posedge clk);
        rc(4'hf, m2[7:0]);
        @(posedge clk);
        batt_above_low <= 1'b0;
        repeat (90) @(posedge clk);
        rc(4'hf, 8'hc0);
        $display("test battery done");
        print_verdict();
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
endmodule // rtc_alarm_interrupt_monitor_test
bind rtcaim_monitor rtcaim_monitor_chk #(.RESET_DELAY_CYC(RESET_DELAY_CYC), .SAMPLE_CYC(SAMPLE_CYC)) u_chk (.clk,
    .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .cur_hour, .cur_minute, .alarm_d_hour,
    .alarm_d_minute, .sec_tick, .main_supply_ok, .osc_running, .batt_cmp_enable, .interrupt_out_n_oe,
    .host_reset_out_n_oe);
